/* include/msb_defines.svh */
// Purpose: Constants for the stop and holding-brake sequencer
// Assumes: 200 MHz pclk
// Notes:   Offsets are byte addresses on the APB slave
`ifndef MSB_DEFINES_SVH
`define MSB_DEFINES_SVH

// ====================================================================
// Register offsets
`define MSB_OFF_STOPCFG 12'h000
`define MSB_OFF_TORQUE 12'h004
`define MSB_OFF_SON_WAIT 12'h008
`define MSB_OFF_SOFF_WAIT 12'h00C
`define MSB_OFF_BRK_SPEED 12'h010
`define MSB_OFF_BRK_WAIT 12'h014
`define MSB_OFF_OUT_ALLOC 12'h018
`define MSB_OFF_CONTROL 12'h01C
`define MSB_OFF_STATUS 12'h020

// ====================================================================
// Reset values and limits
`define MSB_RST_OT_SEL 2'h0
`define MSB_RST_AL_SEL 3'h0
`define MSB_RST_TORQUE 9'h12C
`define MSB_MAX_TORQUE 9'h15E
`define MSB_RST_SON_WAIT 12'h000
`define MSB_MAX_SON_WAIT 12'h7D0
`define MSB_RST_SOFF_WAIT 9'h000
`define MSB_MAX_SOFF_WAIT 9'h1F4
`define MSB_RST_BRK_SPEED 7'h64
`define MSB_MIN_BRK_SPEED 7'h0A
`define MSB_MAX_BRK_SPEED 7'h64
`define MSB_RST_BRK_WAIT 16'h0032
`define MSB_RST_OUT_ALLOC 8'hFF
`define MSB_ALLOC_BRAKE 4'h4

// ====================================================================
// Field positions
`define MSB_CTL_SERVO_ON   0
`define MSB_CTL_ALM_RESET  1
`define MSB_CTL_RESTART    2

// ====================================================================
// Timing
`define MSB_CLK_MHZ        200
`define MSB_TICK_US        1000
`define MSB_TICK_CYCLES    (`MSB_CLK_MHZ * `MSB_TICK_US)
`define MSB_STEP_MS        10

`endif

/* include/msb_pkg.sv */
// Purpose: Types for the stop and holding-brake sequencer
// Assumes: Nothing beyond the defines header
// Notes:   Shared by overtravel and alarm
package msb_pkg;

    // ================================================================
    // Stop action while decelerating
    typedef enum logic [1:0] {
        MSB_STOP_NONE,
        MSB_STOP_DB,
        MSB_STOP_COAST,
        MSB_STOP_REVERSE
    } msb_stop_type;

    // State after standstill
    typedef enum logic [1:0] {
        MSB_AFTER_COAST,
        MSB_AFTER_DB,
        MSB_AFTER_CLAMP,
        MSB_AFTER_RUN
    } msb_after_type;

    typedef struct packed {
        msb_stop_type  stop;
        msb_after_type after;
    } msb_plan_type;

    // Drive commands toward the power stage
    typedef struct packed {
        logic       motor_power;
        logic       dyn_brake;
        logic       zero_clamp;
        logic       speed_ref_zero;
        logic       ramp_bypass;
        logic       torque_limit_en;
        logic [8:0] torque_limit;
    } msb_drive_type;

endpackage

/* rtl/msb_ms_tick.sv */
// Purpose: One-millisecond tick from pclk
// Assumes: pclk at 200 MHz
// Notes:   Free-running; frozen by clock enable
`timescale 1ns/1ps
`include "msb_defines.svh"
module msb_ms_tick #(
    parameter int CYCLES = `MSB_TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    output logic      tick
);
    logic [17:0] count;
    logic [17:0] next_count;
    logic        next_tick;

    // ================================================================
    // Counter
    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (clk_en) begin
            if (count == 18'(CYCLES - 1)) begin
                next_count = 18'h00000;
                next_tick  = 1'b1;
            end else begin
                next_count = count + 18'h00001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 18'h00000;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule

/* rtl/msb_ms_timer.sv */
// Purpose: Millisecond down-counter with restart
// Assumes: Tick is one pclk cycle wide
// Notes:   Done is a level once the count has run out
`timescale 1ns/1ps
module msb_ms_timer (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        tick,
    input  wire logic        start,
    input  wire logic [15:0] load_ms,
    output logic             done
);
    logic [15:0] remain;
    logic [15:0] next_remain;
    logic        running;
    logic        next_running;

    // ================================================================
    // Restart wins over the running count
    always_comb begin
        next_remain  = remain;
        next_running = running;
        if (clk_en) begin
            if (start) begin
                next_remain  = load_ms;
                next_running = 1'b1;
            end else if (running && tick && remain != 16'h0000) begin
                next_remain = remain - 16'h0001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remain  <= 16'h0000;
            running <= 1'b0;
        end else begin
            remain  <= next_remain;
            running <= next_running;
        end
    end

    assign done = running && (remain == 16'h0000) && !start;
endmodule

/* rtl/msb_sequencer.sv */
// Purpose: Stop-method selection and holding-brake sequencing
// Assumes: Speed comes from same-clock logic
// Notes:   Stop selections are captured only on restart
//
// Overview of operation
// R1: Overtravel applies captured stop select 0 to 3.
// R2: Reverse brake zeroes speed reference and bypasses soft start.
// R3: Second-group alarm applies captured select 0 to 5.
// R4: Warning-mode alarm still latches until manual reset.
// R5: Alarm select 3 or 4 limits stopping torque to reverse brake limit.
// R6: Reverse torque limit 0..350 percent, default 300, immediate.
// R7: Host waits 50 ms plus brake release before references.
// R8: Brake output falls on servo off or alarm; high means released.
// R9: Brake output reaches a pin pair only when allocation code is 4.
// R10: Stopped motor: brake at once on servo off, power after off wait.
// R11: Positive on wait: release brake first, power after that many ms.
// R12: Negative on wait: power at once, release brake after magnitude.
// R13: Alarm cuts motor power at once, ignoring servo off wait; on alarm select 3 or 4 the code keeps motor power on until zero speed.
// R14: Running motor: brake when speed below threshold after power off; on an alarm stop the code brakes only at zero speed.
// R15: Running motor: brake also when brake wait expires; on an alarm stop the code restarts the brake wait every cycle.
// R16: All timers share a 1 ms tick and restart on each new event.
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "msb_defines.svh"
module msb_sequencer (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              overtravel_pin,
    input  wire logic              second_group_alarm_pin,
    input  wire logic [15:0]       motor_speed_rpm,
    output msb_pkg::msb_drive_type drive,
    output logic                   brake_release_output,
    output logic      [1:0]        brake_pin_pair
);
    // ================================================================
    // Pin synchronisers
    logic [1:0] ot_sync;
    logic [1:0] al_sync;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ot_sync <= 2'h0;
            al_sync <= 2'h0;
        end else if (clk_en) begin
            ot_sync <= {ot_sync[0], overtravel_pin};
            al_sync <= {al_sync[0], second_group_alarm_pin};
        end
    end
    wire ot_now = ot_sync[1];
    wire al_now = al_sync[1];

    // ================================================================
    // Registers
    logic [1:0]  overtravel_stop_select;
    logic [2:0]  alarm2_stop_select;
    logic [1:0]  ot_pending;
    logic [2:0]  al_pending;
    logic [8:0]  reverse_brake_torque_limit;
    logic [11:0] son_mag;
    logic        son_neg;
    logic [8:0]  servo_off_wait_time;
    logic [6:0]  brake_speed_threshold;
    logic [15:0] brake_wait_time;
    logic [7:0]  output_pin_allocation;
    logic        servo_on_cmd;
    logic        alarm_latch;

    wire wr = psel && penable && pwrite && clk_en;
    wire ctl_wr = wr && paddr == `MSB_OFF_CONTROL;

    // Clamp a written value into its legal range
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Plan for overtravel
    function automatic msb_pkg::msb_plan_type ot_plan(input logic [1:0] s);
        unique case (s)
            2'h0: ot_plan = '{msb_pkg::MSB_STOP_DB, msb_pkg::MSB_AFTER_COAST};
            2'h1: ot_plan = '{msb_pkg::MSB_STOP_DB, msb_pkg::MSB_AFTER_DB};
            2'h2: ot_plan = '{msb_pkg::MSB_STOP_REVERSE, msb_pkg::MSB_AFTER_CLAMP};
            2'h3: ot_plan = '{msb_pkg::MSB_STOP_REVERSE, msb_pkg::MSB_AFTER_COAST};
        endcase
    endfunction

    // Plan for second-group alarm; codes 6 and 7 fall back to the default
    function automatic msb_pkg::msb_plan_type al_plan(input logic [2:0] s);
        case (s)
            3'h1: al_plan = '{msb_pkg::MSB_STOP_DB, msb_pkg::MSB_AFTER_DB};
            3'h2: al_plan = '{msb_pkg::MSB_STOP_COAST, msb_pkg::MSB_AFTER_COAST};
            3'h3: al_plan = '{msb_pkg::MSB_STOP_REVERSE, msb_pkg::MSB_AFTER_DB};
            3'h4: al_plan = '{msb_pkg::MSB_STOP_REVERSE, msb_pkg::MSB_AFTER_COAST};
            3'h5: al_plan = '{msb_pkg::MSB_STOP_NONE, msb_pkg::MSB_AFTER_RUN};
            default: al_plan = '{msb_pkg::MSB_STOP_DB, msb_pkg::MSB_AFTER_COAST};
        endcase
    endfunction

    // Next-value logic for the register file
    logic [1:0]  next_ot_sel, next_ot_pend;
    logic [2:0]  next_al_sel, next_al_pend;
    logic [8:0]  next_torque, next_soff;
    logic [11:0] next_son_mag;
    logic        next_son_neg, next_servo_on, next_alarm_latch;
    logic [6:0]  next_spd;
    logic [15:0] next_bwait;
    logic [7:0]  next_alloc;
    logic [11:0] son_in;
    always_comb begin
        next_ot_sel = overtravel_stop_select;
        next_al_sel = alarm2_stop_select;
        next_ot_pend = ot_pending;
        next_al_pend = al_pending;
        next_torque = reverse_brake_torque_limit;
        next_son_mag = son_mag;
        next_son_neg = son_neg;
        next_soff = servo_off_wait_time;
        next_spd = brake_speed_threshold;
        next_bwait = brake_wait_time;
        next_alloc = output_pin_allocation;
        next_servo_on = servo_on_cmd;
        next_alarm_latch = alarm_latch;
        son_in = pwdata[31] ? 12'(-pwdata[11:0]) : pwdata[11:0];
        if (wr) begin
            unique case (paddr)
                `MSB_OFF_STOPCFG: begin
                    next_ot_pend = pwdata[1:0];
                    next_al_pend = pwdata[6:4];
                end
                `MSB_OFF_TORQUE: next_torque = 9'(clamp16(pwdata[15:0], 16'h0000, 16'(`MSB_MAX_TORQUE))); // R6
                `MSB_OFF_SON_WAIT: begin
                    next_son_mag = 12'(clamp16({4'h0, son_in}, 16'h0000, 16'(`MSB_MAX_SON_WAIT)));
                    next_son_neg = pwdata[31];
                end
                `MSB_OFF_SOFF_WAIT: next_soff = 9'(clamp16(pwdata[15:0], 16'h0000, 16'(`MSB_MAX_SOFF_WAIT)));
                `MSB_OFF_BRK_SPEED: next_spd = 7'(clamp16(pwdata[15:0], 16'(`MSB_MIN_BRK_SPEED),
                                                         16'(`MSB_MAX_BRK_SPEED)));
                `MSB_OFF_BRK_WAIT: next_bwait = pwdata[15:0];
                `MSB_OFF_OUT_ALLOC: next_alloc = pwdata[7:0];
                `MSB_OFF_CONTROL: next_servo_on = pwdata[`MSB_CTL_SERVO_ON];
                default: ;
            endcase
        end
        // Selections take effect only at restart
        if (ctl_wr && pwdata[`MSB_CTL_RESTART]) begin
            next_ot_sel = ot_pending; // R1
            next_al_sel = al_pending; // R3
        end
        // Latched even in warning mode; a live alarm beats the reset
        if (ctl_wr && pwdata[`MSB_CTL_ALM_RESET])
            next_alarm_latch = 1'b0; // R4
        if (clk_en && al_now)
            next_alarm_latch = 1'b1; // R4
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overtravel_stop_select <= `MSB_RST_OT_SEL;
            alarm2_stop_select <= `MSB_RST_AL_SEL;
            ot_pending <= `MSB_RST_OT_SEL;
            al_pending <= `MSB_RST_AL_SEL;
            reverse_brake_torque_limit <= `MSB_RST_TORQUE;
            son_mag <= `MSB_RST_SON_WAIT;
            son_neg <= 1'b0;
            servo_off_wait_time <= `MSB_RST_SOFF_WAIT;
            brake_speed_threshold <= `MSB_RST_BRK_SPEED;
            brake_wait_time <= `MSB_RST_BRK_WAIT;
            output_pin_allocation <= `MSB_RST_OUT_ALLOC;
            servo_on_cmd <= 1'b0;
            alarm_latch <= 1'b0;
        end else begin
            overtravel_stop_select <= next_ot_sel;
            alarm2_stop_select <= next_al_sel;
            ot_pending <= next_ot_pend;
            al_pending <= next_al_pend;
            reverse_brake_torque_limit <= next_torque;
            son_mag <= next_son_mag;
            son_neg <= next_son_neg;
            servo_off_wait_time <= next_soff;
            brake_speed_threshold <= next_spd;
            brake_wait_time <= next_bwait;
            output_pin_allocation <= next_alloc;
            servo_on_cmd <= next_servo_on;
            alarm_latch <= next_alarm_latch;
        end
    end

    // ================================================================
    // Shared tick and three restartable timers
    logic tick;
    msb_ms_tick u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .tick    (tick)
    );

    typedef enum logic [2:0] {
        SQ_OFF, SQ_ON_WAIT, SQ_ON, SQ_OFF_WAIT, SQ_BRAKE_WAIT
    } msb_seq_type;
    msb_seq_type state, next_state;

    logic son_start, soff_start, bwait_start;
    logic son_done, soff_done, bwait_done;
    msb_ms_timer u_son (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .tick(tick),
        .start(son_start), .load_ms({4'h0, son_mag}), .done(son_done)
    ); // R16
    msb_ms_timer u_soff (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .tick(tick),
        .start(soff_start), .load_ms(16'(servo_off_wait_time * `MSB_STEP_MS)),
        .done(soff_done)
    ); // R16
    msb_ms_timer u_bwait (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .tick(tick),
        .start(bwait_start), .load_ms(16'(brake_wait_time * `MSB_STEP_MS)),
        .done(bwait_done)
    ); // R16

    // ================================================================
    // Stop-method selection; a warning-mode alarm does not stop
    msb_pkg::msb_plan_type ap, op;
    logic alarm_stop, stopping, moving, below;
    always_comb begin
        ap = al_plan(alarm2_stop_select);
        op = ot_plan(overtravel_stop_select);
        alarm_stop = alarm_latch && ap.stop != msb_pkg::MSB_STOP_NONE; // R3
        moving = motor_speed_rpm != 16'h0000;
        below  = motor_speed_rpm < {9'h000, brake_speed_threshold};
    end

    // Power and brake sequencing
    logic power, release_brk, next_power, next_release;
    always_comb begin
        next_state   = state;
        next_power   = power;
        next_release = release_brk;
        son_start    = 1'b0;
        soff_start   = 1'b0;
        bwait_start  = 1'b0;
        stopping     = alarm_stop || ot_now;
        if (clk_en) begin
            if (alarm_stop) begin
                next_power   = 1'b0; // R13
                next_release = 1'b0; // R8
                next_state   = SQ_OFF;
                if (release_brk && moving) begin
                    next_release = 1'b1;
                    bwait_start  = 1'b1;
                    next_state   = SQ_BRAKE_WAIT;
                end
            end else begin
                unique case (state)
                    SQ_OFF: if (servo_on_cmd) begin
                        son_start    = 1'b1; // R16
                        next_state   = SQ_ON_WAIT;
                        next_release = !son_neg || son_mag == 12'h000; // R11
                        next_power   = son_neg || son_mag == 12'h000; // R12
                    end
                    SQ_ON_WAIT: if (!servo_on_cmd) begin
                        next_state   = SQ_OFF;
                        next_release = 1'b0;
                        next_power   = 1'b0;
                    end else if (son_done) begin
                        next_release = 1'b1; // R12
                        next_power   = 1'b1; // R11
                        next_state   = SQ_ON;
                    end
                    SQ_ON: if (!servo_on_cmd) begin
                        if (moving) begin
                            next_power  = 1'b0;
                            bwait_start = 1'b1; // R15
                            next_state  = SQ_BRAKE_WAIT;
                        end else begin
                            next_release = 1'b0; // R10
                            soff_start   = 1'b1; // R10
                            next_state   = SQ_OFF_WAIT;
                        end
                    end
                    SQ_OFF_WAIT: if (soff_done) begin
                        next_power = 1'b0; // R10
                        next_state = SQ_OFF;
                    end
                    SQ_BRAKE_WAIT: if (below || bwait_done) begin
                        next_release = 1'b0; // R14 R15
                        next_state   = SQ_OFF;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SQ_OFF;
            power <= 1'b0;
            release_brk <= 1'b0;
        end else begin
            state <= next_state;
            power <= next_power;
            release_brk <= next_release;
        end
    end

    // ================================================================
    // Drive commands; reverse brake zeroes speed and bypasses ramp
    msb_pkg::msb_drive_type next_drive;
    msb_pkg::msb_plan_type  pl;
    always_comb begin
        pl = alarm_stop ? ap : op;
        next_drive = '0;
        next_drive.motor_power  = power;
        next_drive.torque_limit = reverse_brake_torque_limit; // R6
        if (stopping) begin
            if (pl.stop == msb_pkg::MSB_STOP_REVERSE && moving) begin
                next_drive.motor_power     = 1'b1;
                next_drive.speed_ref_zero  = 1'b1; // R2
                next_drive.ramp_bypass     = 1'b1; // R2
                next_drive.torque_limit_en = 1'b1; // R5
            end else if (pl.stop == msb_pkg::MSB_STOP_DB && moving) begin
                next_drive.dyn_brake = 1'b1; // R1 R3
                next_drive.motor_power = 1'b0; // R1
            end else if (!moving) begin
                next_drive.dyn_brake  = pl.after == msb_pkg::MSB_AFTER_DB;
                next_drive.zero_clamp = pl.after == msb_pkg::MSB_AFTER_CLAMP; // R1
                next_drive.motor_power = pl.after == msb_pkg::MSB_AFTER_CLAMP;
            end
            if (alarm_stop && pl.stop != msb_pkg::MSB_STOP_REVERSE)
                next_drive.motor_power = 1'b0; // R13
        end
    end

    // Output registers and APB read data
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = 32'h00000000;
        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                `MSB_OFF_STOPCFG:   next_prdata = {25'h0, al_pending, 2'h0, ot_pending};
                `MSB_OFF_TORQUE:    next_prdata = {23'h0, reverse_brake_torque_limit};
                `MSB_OFF_SON_WAIT:  next_prdata = son_neg ? 32'(-{20'h0, son_mag})
                                                          : {20'h0, son_mag};
                `MSB_OFF_SOFF_WAIT: next_prdata = {23'h0, servo_off_wait_time};
                `MSB_OFF_BRK_SPEED: next_prdata = {25'h0, brake_speed_threshold};
                `MSB_OFF_BRK_WAIT:  next_prdata = {16'h0, brake_wait_time};
                `MSB_OFF_OUT_ALLOC: next_prdata = {24'h0, output_pin_allocation};
                `MSB_OFF_CONTROL:   next_prdata = {31'h0, servo_on_cmd};
                `MSB_OFF_STATUS:    next_prdata = {22'h0, alarm2_stop_select,
                                                   overtravel_stop_select, state,
                                                   alarm_latch, release_brk};
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive  <= '0;
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            drive  <= next_drive;
            prdata <= next_prdata;
        end
    end

    // Brake on a pin pair only where allocated
    assign brake_release_output = release_brk;
    assign brake_pin_pair[0] = release_brk && output_pin_allocation[3:0] == `MSB_ALLOC_BRAKE; // R9
    assign brake_pin_pair[1] = release_brk && output_pin_allocation[7:4] == `MSB_ALLOC_BRAKE; // R9
    assign pready  = clk_en;
    assign pslverr = psel && penable && paddr > `MSB_OFF_STATUS;
endmodule

/* tb/msb_motor_model.sv */
// Purpose: Motor and host model at the power side
// Assumes: Host waits for power and brake
// Notes:   Sheds 8 rpm a cycle
`timescale 1ns/1ps
module msb_motor_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        power,
    input  wire logic        hold,
    input  wire logic        free,
    output logic      [15:0] speed
);
    logic [3:0] settle;
    // ================================================================
    // Reference after a settle time; hold decelerates
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle <= 4'h0;
            speed  <= 16'h0000;
        end else begin
            settle <= (power && free) ? settle + 4'(settle != 4'hF) : 4'h0;
            speed  <= (power && !hold && settle == 4'hF) ? 16'h01F4 :
                      (speed > 16'h0008) ? speed - 16'h0008 : 16'h0000;
        end
    end
endmodule

/* tb/msb_seq_assertions.sv */
// Purpose: Port assertions for the sequencer
// Assumes: One pclk domain, reset active low
// Notes:   Bind follows the module
`timescale 1ns/1ps
module msb_seq_assertions (
    input wire logic                   pclk,
    input wire logic                   presetn,
    input wire logic                   clk_en,
    input wire logic [15:0]            motor_speed_rpm,
    input wire msb_pkg::msb_drive_type drive,
    input wire logic                   brake_release_output,
    input wire logic [1:0]             brake_pin_pair
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ================================================================
    // Power dropping at rest must find the brake set
    sequence s_drop; $fell(drive.motor_power) ##0 motor_speed_rpm == 16'h0000; endsequence
    a_stop_drop: assert property (s_drop |-> !brake_release_output)
        else $error("brake released at rest");
    a_pin_gate: assert property (|brake_pin_pair |-> brake_release_output)
        else $error("pin on, brake set");
    a_reverse_ref: assert property (drive.ramp_bypass |-> drive.speed_ref_zero)
        else $error("bypass, live reference");
    a_reverse_cap: assert property (drive.ramp_bypass |-> drive.torque_limit_en)
        else $error("no torque ceiling");
    a_torque_cap: assert property (drive.torque_limit_en |-> drive.torque_limit <= 9'h15E)
        else $error("ceiling too high");
    a_db_unpowered: assert property (drive.dyn_brake |-> !drive.motor_power)
        else $error("dynamic brake while powered");
    a_clamp_powered: assert property (drive.zero_clamp |-> drive.motor_power)
        else $error("zero clamp without power");
    a_frozen_out: assert property (!clk_en |=> $stable(drive) && $stable(brake_release_output))
        else $error("moved while frozen");
endmodule
bind msb_sequencer msb_seq_assertions i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .motor_speed_rpm(motor_speed_rpm), .drive(drive), .brake_pin_pair(brake_pin_pair),
    .brake_release_output(brake_release_output));

/* tb/msb_sequencer_test.sv */
// Purpose: Bench for the stop and brake sequencer
// Assumes: Servo on and off waits stay zero; brake wait keeps its reset value
// Notes:   Only zero-length timers expire; the brake wait never runs out
`timescale 1ns/1ps
module msb_sequencer_test;
    logic                   pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
    logic                   pwrite = 0, ot = 0, alm = 0, pready, pslverr, err, brk;
    logic [11:0]            paddr = 12'h000;
    logic [31:0]            pwdata = 32'h0, prdata, rd;
    logic [15:0]            spd;
    logic [1:0]             pins;
    msb_pkg::msb_drive_type drive;
    int                     fail_count = 0, tests_run = 0, cyc = 0;
    always #2.5 pclk = ~pclk;
    msb_sequencer i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .overtravel_pin(ot), .second_group_alarm_pin(alm),
        .motor_speed_rpm(spd), .drive(drive), .brake_release_output(brk), .brake_pin_pair(pins));
    msb_motor_model i_motor (.pclk(pclk), .presetn(presetn), .power(drive.motor_power),
        .hold(drive.speed_ref_zero | drive.zero_clamp), .free(brk), .speed(spd));
    // ================================================================
    // Helpers
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // Hold until pready at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task automatic give_verdict;
        if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_regs;
        apb(0, 12'h004, 0);
        chk("torque", 32'h12C, rd);
        apb(1, 12'h004, 32'h190);
        apb(0, 12'h004, 0);
        chk("clamp", 32'h15E, rd);
        apb(0, 12'h024, 0);
        chk("slverr", 1, err);
    endtask
    task automatic t_run;
        apb(1, 12'h018, 32'hF4);
        apb(1, 12'h01C, 32'h1);
        wait (spd == 16'h01F4);
        @(negedge pclk);
        chk("pins", 2'b01, pins);
        chk("power", 1, drive.motor_power);
        @(posedge pclk);
        clk_en <= 0;
        repeat (3) @(posedge pclk);
        clk_en <= 1;
        apb(1, 12'h01C, 0);
        chk("held", 1, brk);
        wait (brk === 1'b0);
        chk("slow", 1, spd < 16'h0064);
    endtask
    task automatic t_ot;
        apb(1, 12'h000, 32'h2);
        apb(1, 12'h01C, 32'h5);
        wait (spd == 16'h01F4);
        ot <= 1;
        wait (drive.ramp_bypass === 1'b1);
        @(negedge pclk);
        chk("ref zero", 1, drive.speed_ref_zero);
        wait (spd == 16'h0000);
        repeat (2) @(posedge pclk);
        chk("clamp", 1, drive.zero_clamp);
        ot <= 0;
        apb(1, 12'h01C, 0);
    endtask
    task automatic t_alarm;
        apb(1, 12'h000, 32'h50);
        apb(1, 12'h01C, 32'h5);
        alm <= 1;
        repeat (4) @(posedge pclk);
        alm <= 0;
        chk("running", 1, drive.motor_power);
        apb(0, 12'h020, 0);
        chk("latched", 1, rd[1]);
        apb(1, 12'h01C, 32'h3);
        apb(0, 12'h020, 0);
        chk("cleared", 0, rd[1]);
    endtask
    // Hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            give_verdict;
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_run;
        t_ot;
        t_alarm;
        give_verdict;
    end
endmodule
